// >>> serial_port_pkg.sv
// Purpose: shared constants for the weld-data serial port
// Assumes: 100 MHz ref_clk, classic Wishbone register access
// Notes:   one register per aligned 32-bit word
package serial_port_pkg;
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          BAUD_MODBUS     = 19200;
    localparam int          BAUD_PRINT      = 9600;
    localparam int          BIT_CYC_MODBUS  = CLK_HZ / BAUD_MODBUS;
    localparam int          BIT_CYC_PRINT   = CLK_HZ / BAUD_PRINT;
    localparam logic [6:0]  GAP_HALF_BITS   = 7'h4D;   // 38.5 bit times, in half bits
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_UNIT        = 8'h04;
    localparam logic [7:0]  OFS_STAT        = 8'h08;
    localparam logic [7:0]  OFS_DATA        = 8'h0C;
    localparam int          CTRL_PRINT      = 0;
    localparam int          CTRL_RS485      = 1;
    localparam int          ST_RX_FULL      = 0;
    localparam int          ST_FRAME_DONE   = 1;
    localparam int          ST_FRAME_GOOD   = 2;
    localparam int          ST_TX_BUSY      = 3;
    localparam int          ST_XOFF         = 4;
    localparam int          ST_PRINT_PEND   = 5;
    localparam int          ST_PERR         = 6;
    localparam logic [1:0]  CTRL_RESET      = 2'h0;
    localparam logic [6:0]  UNIT_RESET      = 7'h01;
    localparam logic [6:0]  UNIT_MIN        = 7'h01;
    localparam logic [6:0]  UNIT_MAX        = 7'h63;
    localparam logic [7:0]  CHAR_XON        = 8'h11;
    localparam logic [7:0]  CHAR_XOFF       = 8'h13;
    localparam logic [7:0]  BROADCAST       = 8'h00;
endpackage : serial_port_pkg

// >>> char_engine.sv
// Purpose: one-character serial transmitter and receiver
// Assumes: rxd already synchronised to ref_clk
// Notes:   start, 8 data lsb first, optional even parity, one stop
`timescale 1ns/100ps
`default_nettype none
module char_engine
    import serial_port_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic [13:0] bit_cyc,
    input  wire logic        parity_on,
    input  wire logic        rxd,
    input  wire logic        tx_start,
    input  wire logic [7:0]  tx_byte,
    output logic             tx_busy,
    output logic             txd,
    output logic             rx_valid,
    output logic [7:0]       rx_byte,
    output logic             rx_perr
);
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;

    logic [10:0] tx_sh, next_tx_sh;
    logic [3:0]  tx_left, next_tx_left;
    logic [13:0] tx_cnt, next_tx_cnt;
    logic        next_txd;

    rx_state_t   rx_st, next_rx_st;
    logic [13:0] rx_cnt, next_rx_cnt;
    logic [3:0]  rx_idx, next_rx_idx;
    logic [8:0]  rx_sh, next_rx_sh;
    logic        next_rx_valid, next_rx_perr;
    logic [7:0]  next_rx_byte;

    assign tx_busy = (tx_left != 4'h0);

    always_comb begin
        next_tx_sh   = tx_sh;
        next_tx_left = tx_left;
        next_tx_cnt  = tx_cnt;
        next_txd     = txd;
        if (tx_left == 4'h0) begin
            next_txd = 1'b1;
            if (tx_start) begin
                // frame: start, data lsb first, parity if enabled, stop
                next_tx_sh   = parity_on ? {1'b1, ^tx_byte, tx_byte, 1'b0}
                                         : {1'b1, 1'b1, tx_byte, 1'b0};
                next_tx_left = parity_on ? 4'hB : 4'hA;
                next_tx_cnt  = 14'h0000;
            end
        end else begin
            next_txd = tx_sh[0];
            if (tx_cnt == bit_cyc - 14'h0001) begin
                next_tx_cnt  = 14'h0000;
                next_tx_sh   = {1'b1, tx_sh[10:1]};
                next_tx_left = tx_left - 4'h1;
            end else begin
                next_tx_cnt = tx_cnt + 14'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            tx_sh   <= 11'h7FF;
            tx_left <= 4'h0;
            tx_cnt  <= 14'h0000;
            txd     <= 1'b1;
        end else if (ce) begin
            tx_sh   <= next_tx_sh;
            tx_left <= next_tx_left;
            tx_cnt  <= next_tx_cnt;
            txd     <= next_txd;
        end
    end

    always_comb begin
        next_rx_st    = rx_st;
        next_rx_cnt   = rx_cnt;
        next_rx_idx   = rx_idx;
        next_rx_sh    = rx_sh;
        next_rx_valid = 1'b0;
        next_rx_byte  = rx_byte;
        next_rx_perr  = rx_perr;
        unique case (rx_st)
            RX_IDLE: begin
                next_rx_cnt = 14'h0000;
                if (!rxd) begin
                    next_rx_st = RX_START;
                end
            end
            RX_START: begin
                if (rx_cnt == {1'b0, bit_cyc[13:1]}) begin
                    next_rx_cnt = 14'h0000;
                    next_rx_idx = 4'h0;
                    next_rx_st  = rxd ? RX_IDLE : RX_BITS;
                end else begin
                    next_rx_cnt = rx_cnt + 14'h0001;
                end
            end
            RX_BITS: begin
                if (rx_cnt == bit_cyc - 14'h0001) begin
                    next_rx_cnt = 14'h0000;
                    next_rx_idx = rx_idx + 4'h1;
                    if (rx_idx == (parity_on ? 4'h9 : 4'h8)) begin
                        // stop bit sampled: deliver, check even parity
                        next_rx_st    = RX_IDLE;
                        next_rx_valid = 1'b1;
                        next_rx_byte  = rx_sh[7:0];
                        next_rx_perr  = parity_on && (rx_sh[8] != ^rx_sh[7:0]);
                    end else if (rx_idx < 4'h8) begin
                        next_rx_sh = {rx_sh[8], rxd, rx_sh[7:1]};
                    end else begin
                        next_rx_sh = {rxd, rx_sh[7:0]};
                    end
                end else begin
                    next_rx_cnt = rx_cnt + 14'h0001;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rx_st    <= RX_IDLE;
            rx_cnt   <= 14'h0000;
            rx_idx   <= 4'h0;
            rx_sh    <= 9'h000;
            rx_valid <= 1'b0;
            rx_byte  <= 8'h00;
            rx_perr  <= 1'b0;
        end else if (ce) begin
            rx_st    <= next_rx_st;
            rx_cnt   <= next_rx_cnt;
            rx_idx   <= next_rx_idx;
            rx_sh    <= next_rx_sh;
            rx_valid <= next_rx_valid;
            rx_byte  <= next_rx_byte;
            rx_perr  <= next_rx_perr;
        end
    end

    property p_tx_idle_high;
        @(posedge ref_clk) disable iff (!rstn)
        (ce && !tx_busy && !tx_start) |=> txd;
    endproperty
    a_tx_idle_high: assert property (p_tx_idle_high)
        else $error("line not idle high");

    property p_tx_start_bit;
        @(posedge ref_clk) disable iff (!rstn)
        (ce && !tx_busy && tx_start) ##1 ce |=> !txd;
    endproperty
    a_tx_start_bit: assert property (p_tx_start_bit)
        else $error("start bit missing");
endmodule : char_engine
`default_nettype wire

// >>> serial_port.sv
// Purpose: Modbus RTU server port and weld label printer output
// Assumes: software handles Modbus PDU and label text
// Notes:   registers on classic Wishbone, one word each
// Behaviour
// - Modbus mode on RS232 runs as an RTU server at 19200 baud, even parity.
// - Modbus characters have one start bit then eight data bits, lsb first, binary.
// - Modbus characters carry a parity bit after the data and exactly one stop bit.
// - RS485 runs as an RTU server at 19200 baud even parity, address settable 1 to 99.
// - Print mode uses RS232 at 9600 baud, 8 bits, no parity, one stop, honouring XON/XOFF.
// - Print mode sends a block of ASCII weld data over RS232 after each completed weld.
// - While print mode is selected the Ethernet and RS485 links are unavailable.
`timescale 1ns/100ps
`default_nettype none
module serial_port
    import serial_port_pkg::*;
#(
    parameter logic [13:0] BIT_CYC_MB = 14'(BIT_CYC_MODBUS),
    parameter logic [13:0] BIT_CYC_PR = 14'(BIT_CYC_PRINT)
)(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        weld_done,
    input  wire logic        rs232_rxd,
    output logic             rs232_txd,
    input  wire logic        rs485_rxd,
    output logic             rs485_txd,
    output logic             rs485_de,
    output logic             eth_en
);
    logic [1:0]  s232, s485;
    logic [1:0]  ctrl, next_ctrl;
    logic [6:0]  unit, next_unit;
    logic [7:0]  rx_data, next_rx_data, tx_hold, next_tx_hold;
    logic        rx_full, next_rx_full, frame_done, next_frame_done;
    logic        frame_good, next_frame_good, perr_st, next_perr_st;
    logic        print_pend, next_print_pend, xoff, next_xoff;
    logic        tx_pend, next_tx_pend, in_frame, next_in_frame;
    logic        frame_bad, next_frame_bad, addr_ok, next_addr_ok;
    logic [20:0] gap_cnt, next_gap_cnt;
    logic        next_ack, next_txd232, next_txd485, next_de, next_eth;
    logic [31:0] next_dat;
    logic        print_mode, use485, rxd_sel, tx_start, req, wr, rd_data;
    logic [13:0] bit_cyc;
    logic [20:0] gap_lim;
    logic        eng_busy, eng_txd, eng_valid, eng_perr;
    logic [7:0]  eng_byte;

    assign print_mode = ctrl[CTRL_PRINT];
    assign use485     = ctrl[CTRL_RS485] && !print_mode;
    assign bit_cyc    = print_mode ? BIT_CYC_PR : BIT_CYC_MB;
    assign rxd_sel    = use485 ? s485[1] : s232[1];
    assign gap_lim    = ({7'h00, bit_cyc} * {14'h0000, GAP_HALF_BITS}) >> 1;
    // printer flow control holds back the next character only
    assign tx_start   = tx_pend && !eng_busy && !(print_mode && xoff);
    assign req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr         = req && wb_we_i && wb_sel_i[0];
    assign rd_data    = req && !wb_we_i && (wb_adr_i == OFS_DATA);

    char_engine u_engine (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .ce        (ce),
        .bit_cyc   (bit_cyc),
        .parity_on (!print_mode),
        .rxd       (rxd_sel),
        .tx_start  (tx_start),
        .tx_byte   (tx_hold),
        .tx_busy   (eng_busy),
        .txd       (eng_txd),
        .rx_valid  (eng_valid),
        .rx_byte   (eng_byte),
        .rx_perr   (eng_perr)
    );

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s232 <= 2'h3;
            s485 <= 2'h3;
        end else if (ce) begin
            s232 <= {s232[0], rs232_rxd};
            s485 <= {s485[0], rs485_rxd};
        end
    end

    always_comb begin
        next_ctrl       = ctrl;
        next_unit       = unit;
        next_rx_data    = rx_data;
        next_rx_full    = rx_full && !rd_data;
        next_frame_done = frame_done;
        next_frame_good = frame_good;
        next_perr_st    = perr_st;
        next_print_pend = print_pend;
        next_xoff       = xoff;
        next_tx_hold    = tx_hold;
        next_tx_pend    = tx_pend && !tx_start;
        next_in_frame   = in_frame;
        next_frame_bad  = frame_bad;
        next_addr_ok    = addr_ok;
        next_gap_cnt    = gap_cnt;
        next_ack        = req;
        next_dat        = 32'h0000_0000;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                OFS_CTRL: next_dat = {30'h0, ctrl};
                OFS_UNIT: next_dat = {25'h0, unit};
                OFS_STAT: next_dat = {25'h0, perr_st, print_pend, xoff, tx_pend | eng_busy,
                                      frame_good, frame_done, rx_full};
                OFS_DATA: next_dat = {24'h0, rx_data};
                default:  next_dat = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            unique case (wb_adr_i)
                OFS_CTRL: next_ctrl = wb_dat_i[1:0];
                OFS_UNIT: begin
                    if (wb_dat_i[6:0] >= UNIT_MIN && wb_dat_i[6:0] <= UNIT_MAX
                        && wb_dat_i[31:7] == 25'h0) begin
                        next_unit = wb_dat_i[6:0];
                    end
                end
                OFS_STAT: begin
                    if (wb_dat_i[ST_FRAME_DONE]) next_frame_done = 1'b0;
                    if (wb_dat_i[ST_PRINT_PEND]) next_print_pend = 1'b0;
                    if (wb_dat_i[ST_PERR])       next_perr_st    = 1'b0;
                end
                OFS_DATA: begin
                    if (!tx_pend) begin
                        next_tx_hold = wb_dat_i[7:0];
                        next_tx_pend = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (!print_mode) begin
            next_xoff = 1'b0;
        end
        // each completed weld in print mode asks software for a label block
        if (weld_done && print_mode) begin
            next_print_pend = 1'b1;
        end
        if (eng_valid) begin
            next_gap_cnt = 21'h0;
            if (print_mode) begin
                if (eng_byte == CHAR_XOFF) begin
                    next_xoff = 1'b1;
                end else if (eng_byte == CHAR_XON) begin
                    next_xoff = 1'b0;
                end else begin
                    next_rx_data = eng_byte;
                    next_rx_full = 1'b1;
                end
            end else begin
                next_rx_data  = eng_byte;
                next_rx_full  = 1'b1;
                next_in_frame = 1'b1;
                if (!in_frame) begin
                    next_addr_ok   = (eng_byte == {1'b0, unit}) || (eng_byte == BROADCAST);
                    next_frame_bad = eng_perr;
                end else if (eng_perr) begin
                    next_frame_bad = 1'b1;
                end
                if (eng_perr) begin
                    next_perr_st = 1'b1;
                end
            end
        end else if (in_frame) begin
            if (gap_cnt >= gap_lim) begin
                next_in_frame   = 1'b0;
                next_frame_done = 1'b1;
                next_frame_good = addr_ok && !frame_bad;
            end else begin
                next_gap_cnt = gap_cnt + 21'h1;
            end
        end
        next_txd232 = use485 ? 1'b1 : eng_txd;
        next_txd485 = use485 ? eng_txd : 1'b1;
        next_de     = use485 && (eng_busy || tx_start);
        next_eth    = !print_mode;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl       <= CTRL_RESET;
            unit       <= UNIT_RESET;
            rx_data    <= 8'h00;
            rx_full    <= 1'b0;
            frame_done <= 1'b0;
            frame_good <= 1'b0;
            perr_st    <= 1'b0;
            print_pend <= 1'b0;
            xoff       <= 1'b0;
            tx_hold    <= 8'h00;
            tx_pend    <= 1'b0;
            in_frame   <= 1'b0;
            frame_bad  <= 1'b0;
            addr_ok    <= 1'b0;
            gap_cnt    <= 21'h0;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0000_0000;
            rs232_txd  <= 1'b1;
            rs485_txd  <= 1'b1;
            rs485_de   <= 1'b0;
            eth_en     <= 1'b1;
        end else if (ce) begin
            ctrl       <= next_ctrl;
            unit       <= next_unit;
            rx_data    <= next_rx_data;
            rx_full    <= next_rx_full;
            frame_done <= next_frame_done;
            frame_good <= next_frame_good;
            perr_st    <= next_perr_st;
            print_pend <= next_print_pend;
            xoff       <= next_xoff;
            tx_hold    <= next_tx_hold;
            tx_pend    <= next_tx_pend;
            in_frame   <= next_in_frame;
            frame_bad  <= next_frame_bad;
            addr_ok    <= next_addr_ok;
            gap_cnt    <= next_gap_cnt;
            wb_ack_o   <= next_ack;
            wb_dat_o   <= next_dat;
            rs232_txd  <= next_txd232;
            rs485_txd  <= next_txd485;
            rs485_de   <= next_de;
            eth_en     <= next_eth;
        end
    end

    property p_print_no_485;
        @(posedge ref_clk) disable iff (!rstn)
        (ce && print_mode) |=> (!rs485_de && rs485_txd && !eth_en);
    endproperty
    a_print_no_485: assert property (p_print_no_485)
        else $error("rs485 or ethernet active in print mode");

    property p_unit_range;
        @(posedge ref_clk) disable iff (!rstn)
        ##1 (unit >= UNIT_MIN && unit <= UNIT_MAX);
    endproperty
    a_unit_range: assert property (p_unit_range)
        else $error("unit address out of range");

    property p_xoff_holds;
        @(posedge ref_clk) disable iff (!rstn)
        (ce && print_mode && xoff && !eng_busy) |=> !eng_busy;
    endproperty
    a_xoff_holds: assert property (p_xoff_holds)
        else $error("character started during xoff");

    property p_perr_discard;
        @(posedge ref_clk) disable iff (!rstn)
        (ce && eng_valid && eng_perr && !print_mode) |=> frame_bad;
    endproperty
    a_perr_discard: assert property (p_perr_discard)
        else $error("parity error not marking frame bad");

    property p_bad_frame;
        @(posedge ref_clk) disable iff (!rstn)
        (ce && in_frame && !eng_valid && gap_cnt >= gap_lim && frame_bad)
            |=> (frame_done && !frame_good);
    endproperty
    a_bad_frame: assert property (p_bad_frame)
        else $error("frame with parity error marked good");

    property p_rate_modbus;
        @(posedge ref_clk) disable iff (!rstn)
        !print_mode |-> (bit_cyc == BIT_CYC_MB);
    endproperty
    a_rate_modbus: assert property (p_rate_modbus)
        else $error("wrong modbus bit time");

    property p_weld_pend;
        @(posedge ref_clk) disable iff (!rstn)
        (ce && weld_done && print_mode) |=> print_pend;
    endproperty
    a_weld_pend: assert property (p_weld_pend)
        else $error("weld completion not flagged");

    property p_485_route;
        @(posedge ref_clk) disable iff (!rstn)
        (ce && use485) |=> rs232_txd;
    endproperty
    a_485_route: assert property (p_485_route)
        else $error("rs232 driven while rs485 selected");
endmodule : serial_port
`default_nettype wire

// >>> serial_client.sv
// Purpose: far-side serial partner, Modbus client or label printer
// Assumes: the bench calls its tasks; bit time given in ref_clk cycles
// Notes:   line idles high; stop bit is the last level driven
`timescale 1ns/100ps
`default_nettype none
module serial_client (
    input  wire logic ref_clk,
    input  wire logic txd,
    output logic      rxd
);
    initial rxd = 1'b1;

    // no release after the stop bit, so back-to-back calls never double-drive
    task automatic send_char(input logic [7:0] b, input logic par_on,
                             input logic bad_par, input int bitc);
        logic [10:0] frame;
        int          nb;
        frame = {1'b1, (^b) ^ bad_par, b, 1'b0};
        nb = par_on ? 11 : 10;
        if (!par_on) begin
            frame[9] = 1'b1;
        end
        for (int i = 0; i < nb; i++) begin
            rxd <= frame[i];
            repeat (bitc) @(posedge ref_clk);
        end
    endtask : send_char

    task automatic recv_char(input logic par_on, input int bitc, input int lim,
                             output logic got, output logic [7:0] b,
                             output logic par, output logic stp);
        int n;
        n = 0;
        got = 1'b0;
        b = 8'h00;
        par = 1'b0;
        stp = 1'b0;
        while (txd !== 1'b0 && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        if (txd === 1'b0) begin
            got = 1'b1;
            repeat (bitc / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (bitc) @(posedge ref_clk);
                b[i] = txd;
            end
            if (par_on) begin
                repeat (bitc) @(posedge ref_clk);
                par = txd;
            end
            repeat (bitc) @(posedge ref_clk);
            stp = txd;
        end
    endtask : recv_char
endmodule : serial_client
`default_nettype wire

// >>> testbench.sv
// Purpose: self-checking bench for the serial port
// Assumes: short bit times by parameter, ce high except one freeze test
// Notes:   registers reached over classic Wishbone
`timescale 1ns/100ps
`default_nettype none
module testbench
    import serial_port_pkg::*;
();
    localparam int BMB = 16;
    localparam int BPR = 32;
    typedef struct packed {logic w; logic [7:0] adr; logic [31:0] wd; logic [31:0] rx;} row_t;
    typedef struct packed {logic [7:0] addr; logic bad; logic good;} frame_t;
    localparam row_t rows [11] = '{'{1'b0, OFS_CTRL, 32'h0, 32'h0},
        '{1'b0, OFS_UNIT, 32'h0, 32'h1}, '{1'b1, OFS_UNIT, 32'h63, 32'h63},
        '{1'b1, OFS_UNIT, 32'h64, 32'h63}, '{1'b1, OFS_UNIT, 32'h0, 32'h63},
        '{1'b1, OFS_UNIT, 32'h101, 32'h63}, '{1'b1, OFS_UNIT, 32'h1, 32'h1},
        '{1'b1, 8'h10, 32'hFF, 32'h0}, '{1'b1, OFS_UNIT, 32'h5, 32'h5},
        '{1'b1, OFS_CTRL, 32'h2, 32'h2}, '{1'b1, OFS_CTRL, 32'h0, 32'h0}};
    localparam frame_t frames [4] = '{'{8'h05, 1'b0, 1'b1}, '{8'h07, 1'b0, 1'b0},
        '{8'h00, 1'b0, 1'b1}, '{8'h05, 1'b1, 1'b0}};
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        ce = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic        weld_done = 1'b0;
    logic [31:0] wb_dat_o, rdq;
    logic        wb_ack_o, rs232_rxd, rs232_txd, rs485_rxd, rs485_txd, rs485_de, eth_en;
    logic        got, par, stp;
    logic [7:0]  ch;
    int          n_errors = 0;
    int          n_checks = 0;
    int          de_cnt = 0;
    int          de_was;

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (rs485_de === 1'b1) de_cnt <= de_cnt + 1;

    serial_port #(.BIT_CYC_MB(14'(BMB)), .BIT_CYC_PR(14'(BPR))) u_serial_port (
        .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .weld_done(weld_done),
        .rs232_rxd(rs232_rxd), .rs232_txd(rs232_txd), .rs485_rxd(rs485_rxd),
        .rs485_txd(rs485_txd), .rs485_de(rs485_de), .eth_en(eth_en));
    serial_client u_client232 (.ref_clk(ref_clk), .txd(rs232_txd), .rxd(rs232_rxd));
    serial_client u_client485 (.ref_clk(ref_clk), .txd(rs485_txd), .rxd(rs485_rxd));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rdq = wb_dat_o;
        check(32'(wb_ack_o), 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    // address byte then one data byte, then poll until the silence ends the frame
    task automatic frame(input logic l485, input logic [7:0] a, input logic bad);
        int n;
        n = 0;
        if (l485) u_client485.send_char(a, 1'b1, bad, BMB);
        else u_client232.send_char(a, 1'b1, bad, BMB);
        if (l485) u_client485.send_char(8'h03, 1'b1, 1'b0, BMB);
        else u_client232.send_char(8'h03, 1'b1, 1'b0, BMB);
        do begin
            wb(1'b0, OFS_STAT, 32'h0);
            n++;
        end while (rdq[ST_FRAME_DONE] !== 1'b1 && n < 600);
    endtask : frame

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        #600_000;
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        check(32'({rs232_txd, rs485_txd, rs485_de, eth_en}), 32'hD);
        foreach (rows[i]) begin
            if (rows[i].w) wb(1'b1, rows[i].adr, rows[i].wd);
            wb(1'b0, rows[i].adr, 32'h0);
            check(rdq, rows[i].rx);
        end
        wb(1'b1, OFS_DATA, 32'h37);
        u_client232.recv_char(1'b1, BMB, 100, got, ch, par, stp);
        check(32'({got, ch, par, stp}), 32'({1'b1, 8'h37, ^8'h37, 1'b1}));
        check(32'(de_cnt), 32'h0);
        foreach (frames[i]) begin
            frame(1'b0, frames[i].addr, frames[i].bad);
            check(32'({rdq[ST_PERR], rdq[ST_FRAME_GOOD]}),
                  32'({frames[i].bad, frames[i].good}));
            wb(1'b0, OFS_DATA, 32'h0);
            check(rdq[7:0], 8'h03);
            wb(1'b1, OFS_STAT, 32'h62);
        end
        wb(1'b1, OFS_CTRL, 32'h2);
        wb(1'b1, OFS_DATA, 32'hC3);
        u_client485.recv_char(1'b1, BMB, 100, got, ch, par, stp);
        check(32'({got, ch, par, stp}), 32'({1'b1, 8'hC3, ^8'hC3, 1'b1}));
        // driver enable holds until one cycle before the stop bit ends; let it drop before counting
        repeat (BMB) @(posedge ref_clk);
        check(32'(de_cnt >= 11 * BMB), 32'h1);
        check(32'(rs485_de), 32'h0);
        frame(1'b1, 8'h05, 1'b0);
        check(32'(rdq[ST_FRAME_GOOD]), 32'h1);
        check(32'({rs485_de, eth_en}), 32'h1);
        wb(1'b1, OFS_CTRL, 32'h1);
        weld_done <= 1'b1;
        @(posedge ref_clk);
        weld_done <= 1'b0;
        wb(1'b0, OFS_STAT, 32'h0);
        check(32'({rdq[ST_PRINT_PEND], eth_en}), 32'h2);
        wb(1'b1, OFS_DATA, 32'h41);
        u_client232.recv_char(1'b0, BPR, 100, got, ch, par, stp);
        check(32'({got, ch, stp}), 32'({1'b1, 8'h41, 1'b1}));
        u_client232.send_char(CHAR_XOFF, 1'b0, 1'b0, BPR);
        wb(1'b0, OFS_STAT, 32'h0);
        check(32'(rdq[ST_XOFF]), 32'h1);
        wb(1'b1, OFS_DATA, 32'h42);
        u_client232.recv_char(1'b0, BPR, 20 * BPR, got, ch, par, stp);
        check(32'(got), 32'h0);
        fork
            u_client232.send_char(CHAR_XON, 1'b0, 1'b0, BPR);
            u_client232.recv_char(1'b0, BPR, 40 * BPR, got, ch, par, stp);
        join
        check(32'({got, ch, stp}), 32'({1'b1, 8'h42, 1'b1}));
        wb(1'b1, OFS_CTRL, 32'h3);
        de_was = de_cnt;
        wb(1'b1, OFS_DATA, 32'h55);
        u_client232.recv_char(1'b0, BPR, 100, got, ch, par, stp);
        check(32'({got, ch, eth_en}), 32'({1'b1, 8'h55, 1'b0}));
        check(32'(de_cnt - de_was), 32'h0);
        // weld pulse while frozen must leave no trace
        wb(1'b1, OFS_STAT, 32'h20);
        ce <= 1'b0;
        weld_done <= 1'b1;
        @(posedge ref_clk);
        ce <= 1'b1;
        weld_done <= 1'b0;
        wb(1'b0, OFS_STAT, 32'h0);
        check(32'(rdq[ST_PRINT_PEND]), 32'h0);
        rstn <= 1'b0;
        @(posedge ref_clk);
        rstn <= 1'b1;
        wb(1'b0, OFS_UNIT, 32'h0);
        check(rdq, 32'({25'h0, UNIT_RESET}));
        check(32'({rs485_de, eth_en}), 32'h1);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
